// ### rtl/uhci_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef UHCI_DEFINES_SVH
`define UHCI_DEFINES_SVH
`define UHCI_OFS_CMD_STATUS   8'h08
`define UHCI_OFS_INT_STATUS   8'h0c
`define UHCI_OFS_INT_ENABLE   8'h10
`define UHCI_OFS_INT_DISABLE  8'h14
`define UHCI_BIT_HRR          0
`define UHCI_BIT_CTRL_FILL    1
`define UHCI_BIT_BULK_FILL    2
`define UHCI_BIT_OWN_REQ      3
`define UHCI_SOC_LSB          16
`define UHCI_SOC_MSB          17
`define UHCI_EV_SO            0
`define UHCI_EV_DONE_HEAD     1
`define UHCI_EV_FRAME_START   2
`define UHCI_EV_RD            3
`define UHCI_EV_SYS_ERR       4
`define UHCI_EV_FRAME_ROLL    5
`define UHCI_EV_HUB_CHANGE    6
`define UHCI_EV_OWN_CHANGE    30
`define UHCI_BIT_MASTER_EN    31
`define UHCI_EVENT_MASK       32'h4000_007f
`define UHCI_ENABLE_MASK      32'hc000_007f
`define UHCI_CMD_WMASK        32'h0000_000f
`define UHCI_RESET_VALUE      32'h0000_0000
`define UHCI_FS_RESET         2'h0
`define UHCI_FS_RESUME        2'h1
`define UHCI_FS_OPER          2'h2
`define UHCI_FS_SUSPEND       2'h3
`define UHCI_SWRST_NS         80
`define UHCI_CLK_NS           10
`define UHCI_SWRST_CYCLES     ((`UHCI_SWRST_NS + `UHCI_CLK_NS - 1) / `UHCI_CLK_NS)
`endif

// ### rtl/uhci_pkg.sv
// Types shared by the command and interrupt register block
package uhci_pkg;
   typedef logic [31:0] uhci_word_t;
   typedef logic [1:0]  uhci_fs_t;
   typedef enum logic [1:0] {
      UHCI_RST_IDLE,
      UHCI_RST_BUSY,
      UHCI_RST_DONE
   } uhci_rst_e;
endpackage

// ### rtl/uhci_edge_sync.sv
// Two-flop synchroniser with rising edge pulse
module uhci_edge_sync (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic async_in,
   output logic      level_out,
   output logic      rise_out
);
   logic meta;
   logic sync;
   logic prev;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= async_in;
         sync <= meta;
         prev <= sync;
      end
   end
   assign level_out = sync;
   assign rise_out  = sync & ~prev;
endmodule

// ### rtl/uhci_event_flags.sv
// Sticky event flag bank: hardware set wins over software one-to-clear
module uhci_event_flags #(
   parameter int WIDTH = 32
) (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             soft_clear_in,
   input  wire logic [WIDTH-1:0] set_in,
   input  wire logic [WIDTH-1:0] clear_in,
   output logic      [WIDTH-1:0] flags_out
);
   if (WIDTH < 1) begin : g_bad_width
      $error("uhci_event_flags: WIDTH must be positive");
   end
   for (genvar i = 0; i < WIDTH; i++) begin : g_flag
      always_ff @(posedge clk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            flags_out[i] <= 1'b0;
         end else if (soft_clear_in) begin
            // Soft reset holds the bank clear even against fresh events
            flags_out[i] <= 1'b0;
         end else if (set_in[i]) begin
            flags_out[i] <= 1'b1;
         end else if (clear_in[i]) begin
            flags_out[i] <= 1'b0;
         end
      end
   end
endmodule

// ### rtl/uhci_cmd_irq_regs.sv
// Command, status and interrupt control registers of the host controller
`include "uhci_defines.svh"
module uhci_cmd_irq_regs #(
   parameter int  SWRST_CYCLES = `UHCI_SWRST_CYCLES,
   parameter bit  HAS_MGMT_PIN = 1'b1
) (
   input  wire logic               clk_in,
   input  wire logic               rst_n_in,
   input  wire logic [7:0]         reg_addr_in,
   input  wire logic               reg_write_in,
   input  wire logic               reg_read_in,
   input  wire uhci_pkg::uhci_word_t reg_wdata_in,
   output uhci_pkg::uhci_word_t    reg_rdata_out,
   input  wire logic               irq_routing_select_in,
   input  wire logic               fs_write_in,
   input  wire uhci_pkg::uhci_fs_t fs_wdata_in,
   output uhci_pkg::uhci_fs_t      functional_state_out,
   input  wire logic               control_head_reached_in,
   input  wire logic               bulk_head_reached_in,
   output logic                    control_list_start_out,
   output logic                    bulk_list_start_out,
   input  wire logic               changeover_done_in,
   input  wire logic               periodic_overrun_in,
   input  wire logic               done_head_write_req_in,
   output logic                    done_head_write_grant_out,
   input  wire logic               frame_start_in,
   output logic                    sof_token_out,
   input  wire logic [15:0]        frame_number_in,
   input  wire logic               resume_signal_in,
   input  wire logic               system_error_in,
   input  wire logic               root_hub_change_in,
   output logic                    processing_halt_out,
   output logic                    soft_reset_out,
   output logic                    host_irq_out,
   output logic                    mgmt_irq_out
);
   import uhci_pkg::*;

   // A zero-length sequence would wrap the compare value and hold the request bit for 65537 cycles
   if (SWRST_CYCLES < 1) begin : g_short_reset
      $error("uhci_cmd_irq_regs: SWRST_CYCLES must be at least 1");
   end
   // The sequence counter is sixteen bits wide
   if (SWRST_CYCLES > 65536) begin : g_long_reset
      $error("uhci_cmd_irq_regs: SWRST_CYCLES must not exceed 65536");
   end

   uhci_rst_e  rst_state;
   logic [15:0] rst_count;
   logic       host_reset_request;
   logic       control_list_filled;
   logic       bulk_list_filled;
   logic       ownership_request;
   logic [1:0] overrun_count;
   uhci_word_t interrupt_enable;
   uhci_word_t interrupt_status;
   uhci_fs_t   functional_state;
   logic       fn_top_prev;
   logic       resume_level;
   logic       resume_rise;
   logic       sys_err_level;
   logic       sys_err_rise;
   logic       soft_reset;
   logic       wr_cmd;
   logic       wr_sts;
   logic       wr_en;
   logic       wr_dis;
   uhci_word_t event_set;
   uhci_word_t event_clear;
   uhci_word_t pending;

   assign wr_cmd = reg_write_in && (reg_addr_in == `UHCI_OFS_CMD_STATUS);
   assign wr_sts = reg_write_in && (reg_addr_in == `UHCI_OFS_INT_STATUS);
   assign wr_en  = reg_write_in && (reg_addr_in == `UHCI_OFS_INT_ENABLE);
   assign wr_dis = reg_write_in && (reg_addr_in == `UHCI_OFS_INT_DISABLE);

   // Pin-level event sources pass two flops first
   uhci_edge_sync u_resume_sync (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .async_in  (resume_signal_in),
      .level_out (resume_level),
      .rise_out  (resume_rise)
   );
   uhci_edge_sync u_syserr_sync (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .async_in  (system_error_in),
      .level_out (sys_err_level),
      .rise_out  (sys_err_rise)
   );

   // Software reset sequencer; the request bit drops when done
   assign soft_reset = (rst_state == UHCI_RST_BUSY);
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_state <= UHCI_RST_IDLE;
         rst_count <= 16'h0000;
      end else begin
         case (rst_state)
            UHCI_RST_IDLE: begin
               if (wr_cmd && reg_wdata_in[`UHCI_BIT_HRR]) begin
                  rst_state <= UHCI_RST_BUSY;
                  rst_count <= 16'h0000;
               end
            end
            UHCI_RST_BUSY: begin
               if (rst_count == 16'(SWRST_CYCLES - 1)) begin
                  rst_state <= UHCI_RST_DONE;
               end else begin
                  rst_count <= rst_count + 16'h0001;
               end
            end
            UHCI_RST_DONE: rst_state <= UHCI_RST_IDLE;
            default: rst_state <= UHCI_RST_IDLE;
         endcase
      end
   end
   assign host_reset_request = (rst_state != UHCI_RST_IDLE);

   // Functional state: hard reset to reset, soft reset to suspend
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         functional_state <= `UHCI_FS_RESET;
      end else if (soft_reset) begin
         functional_state <= `UHCI_FS_SUSPEND;
      end else if (fs_write_in) begin
         functional_state <= fs_wdata_in;
      end else if (resume_rise && functional_state == `UHCI_FS_SUSPEND) begin
         functional_state <= `UHCI_FS_RESUME;
      end
   end

   // List filled flags: software sets, controller consumes at list head
   assign control_list_start_out = control_head_reached_in && control_list_filled
                                   && !processing_halt_out;
   assign bulk_list_start_out    = bulk_head_reached_in && bulk_list_filled
                                   && !processing_halt_out;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         control_list_filled <= 1'b0;
         bulk_list_filled    <= 1'b0;
      end else if (soft_reset) begin
         control_list_filled <= 1'b0;
         bulk_list_filled    <= 1'b0;
      end else begin
         // A fresh set in the consume cycle survives, so no descriptor is missed
         if (wr_cmd && reg_wdata_in[`UHCI_BIT_CTRL_FILL]) begin
            control_list_filled <= 1'b1;
         end else if (control_list_start_out) begin
            control_list_filled <= 1'b0;
         end
         if (wr_cmd && reg_wdata_in[`UHCI_BIT_BULK_FILL]) begin
            bulk_list_filled <= 1'b1;
         end else if (bulk_list_start_out) begin
            bulk_list_filled <= 1'b0;
         end
      end
   end

   // Ownership request held until changeover finishes
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ownership_request <= 1'b0;
      end else if (soft_reset) begin
         ownership_request <= 1'b0;
      end else if (wr_cmd && reg_wdata_in[`UHCI_BIT_OWN_REQ]) begin
         ownership_request <= 1'b1;
      end else if (changeover_done_in) begin
         ownership_request <= 1'b0;
      end
   end

   // Overrun count ignores the state of its flag
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         overrun_count <= 2'h0;
      end else if (soft_reset) begin
         overrun_count <= 2'h0;
      end else if (periodic_overrun_in) begin
         overrun_count <= overrun_count + 2'h1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fn_top_prev <= 1'b0;
      end else begin
         fn_top_prev <= frame_number_in[15];
      end
   end

   // Event sources into the sticky flag bank
   always_comb begin
      event_set = `UHCI_RESET_VALUE;
      event_set[`UHCI_EV_SO]   = periodic_overrun_in;
      event_set[`UHCI_EV_DONE_HEAD]   = done_head_write_grant_out;
      event_set[`UHCI_EV_FRAME_START] = frame_start_in && !processing_halt_out;
      event_set[`UHCI_EV_RD]          = resume_rise;
      event_set[`UHCI_EV_SYS_ERR]     = sys_err_rise;
      event_set[`UHCI_EV_FRAME_ROLL]  = frame_number_in[15] ^ fn_top_prev;
      event_set[`UHCI_EV_HUB_CHANGE]  = root_hub_change_in;
      event_set[`UHCI_EV_OWN_CHANGE]  = HAS_MGMT_PIN && wr_cmd
                                        && reg_wdata_in[`UHCI_BIT_OWN_REQ];
      event_set = event_set & `UHCI_EVENT_MASK;
   end
   assign event_clear = wr_sts ? (reg_wdata_in & `UHCI_EVENT_MASK) : `UHCI_RESET_VALUE;

   uhci_event_flags #(
      .WIDTH (32)
   ) u_flags (
      .clk_in        (clk_in),
      .rst_n_in      (rst_n_in),
      .soft_clear_in (soft_reset),
      .set_in        (event_set),
      .clear_in      (event_clear),
      .flags_out     (interrupt_status)
   );

   // Write-back blocked while the previous head is unread
   assign done_head_write_grant_out = done_head_write_req_in
                                      && !interrupt_status[`UHCI_EV_DONE_HEAD]
                                      && !processing_halt_out;
   assign sof_token_out = event_set[`UHCI_EV_FRAME_START];
   // Error halt holds while the error input is high and until software or soft reset clears the flag
   assign processing_halt_out = interrupt_status[`UHCI_EV_SYS_ERR] || sys_err_level;
   assign soft_reset_out = soft_reset;

   // Enable register: set via enable, cleared via disable
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         interrupt_enable <= `UHCI_RESET_VALUE;
      end else if (soft_reset) begin
         interrupt_enable <= `UHCI_RESET_VALUE;
      end else if (wr_en) begin
         interrupt_enable <= interrupt_enable
                             | (reg_wdata_in & `UHCI_ENABLE_MASK);
      end else if (wr_dis) begin
         interrupt_enable <= interrupt_enable
                             & ~(reg_wdata_in & `UHCI_ENABLE_MASK);
      end
   end

   // Interrupt gating and routing
   assign pending = interrupt_status & interrupt_enable & `UHCI_EVENT_MASK;
   always_comb begin
      host_irq_out = 1'b0;
      mgmt_irq_out = 1'b0;
      if (interrupt_enable[`UHCI_BIT_MASTER_EN]) begin
         if (irq_routing_select_in) begin
            mgmt_irq_out = |pending;
         end else begin
            host_irq_out = |(pending & ~(32'h1 << `UHCI_EV_OWN_CHANGE));
            mgmt_irq_out = pending[`UHCI_EV_OWN_CHANGE];
         end
      end
   end

   // Registered read data; unmapped addresses read zero
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= `UHCI_RESET_VALUE;
      end else if (reg_read_in) begin
         case (reg_addr_in)
            `UHCI_OFS_CMD_STATUS: begin
               reg_rdata_out <= {14'h0000, overrun_count, 12'h000, ownership_request,
                                 bulk_list_filled, control_list_filled,
                                 host_reset_request};
            end
            `UHCI_OFS_INT_STATUS:  reg_rdata_out <= interrupt_status;
            `UHCI_OFS_INT_ENABLE:  reg_rdata_out <= interrupt_enable;
            `UHCI_OFS_INT_DISABLE: reg_rdata_out <= interrupt_enable;
            default:               reg_rdata_out <= `UHCI_RESET_VALUE;
         endcase
      end
   end

   assign functional_state_out = functional_state;
endmodule

// ### sim/uhci_cmd_irq_properties.sv
// Port-level checks for the command and interrupt register block
`include "uhci_defines.svh"
module uhci_cmd_irq_properties #(
   parameter int SWRST_CYCLES = 8
) (
   input wire logic        clk_in,
   input wire logic        rst_n_in,
   input wire logic [7:0]  reg_addr_in,
   input wire logic        reg_write_in,
   input wire logic        reg_read_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic        irq_routing_select_in,
   input wire logic        control_head_reached_in,
   input wire logic        bulk_head_reached_in,
   input wire logic        control_list_start_out,
   input wire logic        bulk_list_start_out,
   input wire logic        done_head_write_grant_out,
   input wire logic        frame_start_in,
   input wire logic        sof_token_out,
   input wire logic        processing_halt_out,
   input wire logic        soft_reset_out,
   input wire logic        host_irq_out,
   input wire logic        mgmt_irq_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import uhci_pkg::*;
   int srst_len;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // Counts how long the soft reset pulse stays up
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) srst_len <= 0;
      else srst_len <= soft_reset_out ? srst_len + 1 : 0;
   end
   ctrl_start_a: assert property (
      control_list_start_out |-> control_head_reached_in && !processing_halt_out)
      else $error("control start without cause");
   bulk_start_a: assert property (
      bulk_list_start_out |-> bulk_head_reached_in && !processing_halt_out)
      else $error("bulk start without cause");
   sof_token_a: assert property (
      sof_token_out == (frame_start_in && !processing_halt_out))
      else $error("start token mismatch");
   grant_block_a: assert property (
      done_head_write_grant_out && !soft_reset_out && !$past(soft_reset_out)
      |=> !done_head_write_grant_out) else $error("second done head grant");
   route_host_a: assert property (
      host_irq_out |-> !irq_routing_select_in) else $error("host irq while routed");
   mask_all_a: assert property (
      reg_write_in && reg_addr_in == `UHCI_OFS_INT_DISABLE && reg_wdata_in == 32'hffff_ffff
      |=> !host_irq_out && !mgmt_irq_out) else $error("irq after disable all");
   cmd_rsvd_a: assert property (
      reg_read_in && reg_addr_in == `UHCI_OFS_CMD_STATUS
      |=> (reg_rdata_out & 32'hfffc_fff0) == 32'h0) else $error("command reserved set");
   status_rsvd_a: assert property (
      reg_read_in && reg_addr_in == `UHCI_OFS_INT_STATUS
      |=> (reg_rdata_out & 32'hbfff_ff80) == 32'h0) else $error("status reserved set");
   soft_start_a: assert property (
      reg_write_in && reg_addr_in == `UHCI_OFS_CMD_STATUS && reg_wdata_in[0]
      && !soft_reset_out && !$past(soft_reset_out) |=> soft_reset_out)
      else $error("soft reset not started");
   soft_len_a: assert property (
      $fell(soft_reset_out) |-> srst_len == SWRST_CYCLES) else $error("soft reset length");
endmodule
bind uhci_cmd_irq_regs uhci_cmd_irq_properties #(.SWRST_CYCLES(SWRST_CYCLES)) chk (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
   .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_wdata_in(reg_wdata_in),
   .reg_rdata_out(reg_rdata_out), .irq_routing_select_in(irq_routing_select_in),
   .control_head_reached_in(control_head_reached_in),
   .bulk_head_reached_in(bulk_head_reached_in), .control_list_start_out(control_list_start_out),
   .bulk_list_start_out(bulk_list_start_out), .frame_start_in(frame_start_in),
   .done_head_write_grant_out(done_head_write_grant_out), .sof_token_out(sof_token_out),
   .processing_halt_out(processing_halt_out), .soft_reset_out(soft_reset_out),
   .host_irq_out(host_irq_out), .mgmt_irq_out(mgmt_irq_out));

// ### sim/uhci_hcd_model.sv
// Host driver stand-in: register accesses launched on the falling edge
module uhci_driver_model (
   input  wire logic                 clk_in,
   output logic [7:0]                addr_out,
   output logic                      write_out,
   output logic                      read_out,
   output uhci_pkg::uhci_word_t      wdata_out,
   input  wire uhci_pkg::uhci_word_t rdata_in
);
   timeunit 1ns;
   timeprecision 1ps;
   import uhci_pkg::*;
   initial begin
      addr_out = 8'h00;
      write_out = 1'b0;
      read_out = 1'b0;
      wdata_out = 32'h0;
   end
   task automatic wr(input logic [7:0] a, input uhci_word_t v);
      @(negedge clk_in);
      addr_out = a;
      wdata_out = v;
      write_out = 1'b1;
      @(negedge clk_in);
      write_out = 1'b0;
      // Released data bus never keeps the old value
      wdata_out = ~v;
   endtask
   task automatic rd(input logic [7:0] a, output uhci_word_t v);
      @(negedge clk_in);
      addr_out = a;
      read_out = 1'b1;
      @(negedge clk_in);
      read_out = 1'b0;
      v = rdata_in;
   endtask
endmodule

// ### sim/tb_uhci_cmd_irq_regs.sv
// Self-checking bench for the command and interrupt register block
module tb_uhci_cmd_irq_regs;
   timeunit 1ns;
   timeprecision 1ps;
   import uhci_pkg::*;
   logic        clk_in = 1'b0, rst_n_in = 1'b0, ovr = 1'b0, dreq = 1'b0, fst = 1'b0;
   logic        res = 1'b0, serr = 1'b0, rhc = 1'b0, cdone = 1'b0, route = 1'b0, fsw = 1'b0;
   logic [2:1]  hd = 2'h0;
   wire  [2:1]  st;
   uhci_fs_t    fsd = 2'h0, fs;
   logic [15:0] fnum = 16'h0000;
   logic [7:0]  addr;
   logic        wr, rd, grant, sof, halt, srst, hirq, mirq;
   uhci_word_t  wdata, rdata, m_ev = 32'h0, m_en = 32'h0, m_cmd = 32'h0, d, w;
   int          fail_count = 0, n_tests = 0, seed = 34717, cyc = 0, k;
   always #5 clk_in = ~clk_in;
   uhci_cmd_irq_regs #(.SWRST_CYCLES(4)) uut (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_write_in(wr),
      .reg_read_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .irq_routing_select_in(route), .fs_write_in(fsw), .fs_wdata_in(fsd),
      .functional_state_out(fs), .control_head_reached_in(hd[1]),
      .bulk_head_reached_in(hd[2]), .control_list_start_out(st[1]),
      .bulk_list_start_out(st[2]), .changeover_done_in(cdone), .periodic_overrun_in(ovr),
      .done_head_write_req_in(dreq), .done_head_write_grant_out(grant),
      .frame_start_in(fst), .sof_token_out(sof), .frame_number_in(fnum),
      .resume_signal_in(res), .system_error_in(serr), .root_hub_change_in(rhc),
      .processing_halt_out(halt), .soft_reset_out(srst), .host_irq_out(hirq),
      .mgmt_irq_out(mirq));
   uhci_driver_model drv (.clk_in(clk_in), .addr_out(addr), .write_out(wr), .read_out(rd),
      .wdata_out(wdata), .rdata_in(rdata));
   task automatic chk_reg(input uhci_word_t got, input uhci_word_t exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t pin %b expected %b", $time, got, exp);
      end
   endtask
   task automatic rdx(input logic [7:0] a, input uhci_word_t exp);
      drv.rd(a, d);
      chk_reg(d, exp);
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk_in);
      s = 1'b1;
      @(negedge clk_in);
      s = 1'b0;
   endtask
   task automatic chk_irq();
      logic hit;
      hit = (|(m_ev & m_en & 32'h0000_007f)) & m_en[31];
      chk_pin(hirq, hit & ~route);
      chk_pin(mirq, (m_ev[30] & m_en[30] & m_en[31]) | (hit & route));
   endtask
   task automatic note(input int t);
      $display("test %0d done", t);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Whole run is well under a thousand cycles
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         test_done();
      end
   end
   initial begin
      repeat (4) @(negedge clk_in);
      rst_n_in = 1'b1;
      chk_reg(32'(fs), 32'h0);
      for (k = 0; k < 5; k++) rdx(8'h08 + 8'(4 * k), 32'h0);
      note(1);
      pulse(ovr);
      m_cmd[17:16] = 2'h1;
      @(negedge clk_in);
      dreq = 1'b1;
      #1 chk_pin(grant, 1'b1);
      @(negedge clk_in);
      chk_pin(grant, 1'b0);
      dreq = 1'b0;
      fst = 1'b1;
      #1 chk_pin(sof, 1'b1);
      @(negedge clk_in);
      fst = 1'b0;
      fsd = 2'h1;
      pulse(fsw);
      rdx(8'h0c, 32'h0000_0007);
      res = 1'b1;
      pulse(rhc);
      fnum = 16'h8000;
      repeat (4) @(negedge clk_in);
      m_ev = 32'h0000_006f;
      rdx(8'h0c, m_ev);
      rdx(8'h08, m_cmd);
      note(2);
      repeat (3) begin
         w = $random(seed);
         // Done head taken as already saved before clearing its flag
         drv.wr(8'h0c, w);
         m_ev &= ~w;
         rdx(8'h0c, m_ev);
      end
      repeat (2) drv.wr(8'h0c, 32'hffff_ffff);
      m_ev = 32'h0;
      rdx(8'h0c, m_ev);
      repeat (5) begin
         pulse(ovr);
         m_cmd[17:16] += 2'h1;
      end
      m_ev[0] = 1'b1;
      rdx(8'h08, m_cmd);
      rdx(8'h0c, m_ev);
      note(3);
      pulse(rhc);
      pulse(fst);
      m_ev[6] = 1'b1;
      m_ev[2] = 1'b1;
      repeat (8) begin
         w = $random(seed);
         route = w[9];
         drv.wr(8'h10, w);
         m_en |= w & 32'hc000_007f;
         chk_irq();
         w = $random(seed);
         drv.wr(8'h14, w);
         m_en &= ~w;
         rdx(8'h10, m_en);
         rdx(8'h14, m_en);
         chk_irq();
      end
      note(4);
      drv.wr(8'h10, 32'hc000_0000);
      m_en |= 32'hc000_0000;
      drv.wr(8'h08, 32'h0000_0008);
      m_cmd[3] = 1'b1;
      m_ev[30] = 1'b1;
      chk_irq();
      rdx(8'h08, m_cmd);
      rdx(8'h0c, m_ev);
      pulse(cdone);
      m_cmd[3] = 1'b0;
      rdx(8'h08, m_cmd);
      drv.wr(8'h14, 32'hffff_ffff);
      m_en = 32'h0;
      chk_irq();
      note(5);
      serr = 1'b1;
      repeat (4) @(negedge clk_in);
      m_ev[4] = 1'b1;
      chk_pin(halt, 1'b1);
      rdx(8'h0c, m_ev);
      fst = 1'b1;
      #1 chk_pin(sof, 1'b0);
      @(negedge clk_in);
      fst = 1'b0;
      serr = 1'b0;
      drv.wr(8'h08, 32'h0000_0001);
      for (k = 0; k < 40 && srst === 1'b1; k++) @(negedge clk_in);
      chk_reg(32'(k), 32'h4);
      repeat (2) @(negedge clk_in);
      chk_reg(32'(fs), 32'h3);
      chk_pin(halt, 1'b0);
      for (k = 0; k < 3; k++) rdx(8'h08 + 8'(4 * k), 32'h0);
      drv.wr(8'h0c, 32'h0000_0010);
      m_cmd = 32'h0;
      note(6);
      for (k = 1; k < 3; k++) begin
         drv.wr(8'h08, 32'h1 << k);
         m_cmd[k] = 1'b1;
         rdx(8'h08, m_cmd);
         repeat (2) begin
            @(negedge clk_in);
            hd[k] = 1'b1;
            #1 chk_pin(st[k], m_cmd[k]);
            m_cmd[k] = 1'b0;
            @(negedge clk_in);
            hd[k] = 1'b0;
         end
         rdx(8'h08, m_cmd);
      end
      note(7);
      // Downstream resume while suspended moves the state to resume
      res = 1'b0;
      repeat (3) @(negedge clk_in);
      res = 1'b1;
      repeat (4) @(negedge clk_in);
      chk_reg(32'(fs), 32'h1);
      rdx(8'h0c, 32'h0000_0008);
      note(8);
      test_done();
   end
endmodule
